// ===== dmis_pkg.sv
// Constants and carrier types for the data-move and indirect-store unit.
// Assumes a core that presents one decoded instruction per cycle.
// How it works
// RULE_01: The load-literal instruction puts its 8-bit immediate into the accumulator.
// RULE_02: The direct-store instruction writes the accumulator to file register 0..127 and keeps the accumulator.
// RULE_03: The indirect store writes the accumulator to the address held in the chosen pointer; the window holds no data.
// RULE_04: A 1-bit operand picks one of two pointers and a 2-bit mode field picks the variant.
// RULE_05: Mode 00 pre-increments, 01 pre-decrements, 10 post-increments, 11 post-decrements.
// RULE_06: The relative form addresses pointer plus a signed 6-bit offset from -32 to 31.
// RULE_07: Afterwards the pointer is old plus one, old minus one, or unchanged for the relative form.
// RULE_08: Pointers are 16 bits and wrap modulo the full range.
// RULE_09: Pointer updates never touch the status flags.
// RULE_10: Load-literal and direct-store take one word, one cycle, and leave the flags alone.
package dmis_pkg;

	localparam int ACC_W = 8;
	localparam int FADDR_W = 7;
	localparam int PTR_W = 16;
	localparam int OFS_W = 6;
	localparam int NPTR = 2;
	localparam int FLAG_W = 3;

	localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
	localparam logic [FLAG_W-1:0] FLAG_RST = 3'h0;

	typedef enum logic [2:0] {
		DMIS_OP_NONE = 3'b000,
		DMIS_OP_LIT = 3'b001,
		DMIS_OP_DIR = 3'b010,
		DMIS_OP_IND = 3'b011,
		DMIS_OP_REL = 3'b100
	} dmis_op_t;

	typedef enum logic [1:0] {
		DMIS_PREINC = 2'b00,
		DMIS_PREDEC = 2'b01,
		DMIS_POSTINC = 2'b10,
		DMIS_POSTDEC = 2'b11
	} dmis_mode_t;

	typedef struct packed {
		logic valid;
		dmis_op_t op;
		logic [ACC_W-1:0] literal;
		logic [FADDR_W-1:0] faddr;
		logic sel;
		dmis_mode_t mode;
		logic [OFS_W-1:0] offset;
	} dmis_instr_t;

	typedef struct packed {
		logic valid;
		logic indirect;
		logic [PTR_W-1:0] addr;
		logic [ACC_W-1:0] data;
	} dmis_wr_t;

endpackage : dmis_pkg

// ===== dmis_core.sv
// Execution unit for literal load, direct store and indirect store.
// Assumes instructions arrive already decoded, on the core clock, one a
// cycle; memory takes the write port without back-pressure.
`timescale 1ns/10ps
module dmis_core
#(
	// Pointer count and widths; the ports are built for these defaults
	parameter int NPTR = dmis_pkg::NPTR,
	parameter int PTR_W = dmis_pkg::PTR_W,
	parameter int ACC_W = dmis_pkg::ACC_W,
	parameter int FADDR_W = dmis_pkg::FADDR_W,
	parameter int OFS_W = dmis_pkg::OFS_W
)
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Decoded instruction
	input dmis_pkg::dmis_instr_t instr_i,
	// Flags from the ALU, passed through untouched here
	input wire logic [dmis_pkg::FLAG_W-1:0] flags_i,
	// Results
	output logic [dmis_pkg::ACC_W-1:0] acc_o,
	output logic [dmis_pkg::PTR_W-1:0] ptr0_o,
	output logic [dmis_pkg::PTR_W-1:0] ptr1_o,
	output logic [dmis_pkg::FLAG_W-1:0] flags_o,
	output dmis_pkg::dmis_wr_t wr_o
);

	// Elaboration checks: the carrier structs fix most widths
	if (NPTR != dmis_pkg::NPTR)
	begin : g_chk_nptr
		$error("dmis_core: only two pointers reach the ports");
	end

	if (PTR_W != dmis_pkg::PTR_W)
	begin : g_chk_ptr_w
		$error("dmis_core: pointer width is fixed by the write port");
	end

	if (ACC_W != dmis_pkg::ACC_W)
	begin : g_chk_acc_w
		$error("dmis_core: accumulator width is fixed by the ports");
	end

	if (FADDR_W >= PTR_W)
	begin : g_chk_faddr
		// Zero extension of the file address needs spare bits
		$error("dmis_core: file address must be narrower than a pointer");
	end

	if (OFS_W >= PTR_W)
	begin : g_chk_ofs
		// Sign extension of the offset needs spare bits
		$error("dmis_core: offset must be narrower than a pointer");
	end

	if (FADDR_W != dmis_pkg::FADDR_W || OFS_W != dmis_pkg::OFS_W)
	begin : g_chk_operands
		$error("dmis_core: operand widths are fixed by the instruction");
	end

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [NPTR-1:0][PTR_W-1:0] ptr;
		logic [dmis_pkg::FLAG_W-1:0] flags;
		dmis_pkg::dmis_wr_t wr;
	} dmis_state_t;

	// Offsets are two's complement; extension keeps the range exact
	function automatic logic [PTR_W-1:0] sext_ofs(
		input logic [OFS_W-1:0] v
	);
		sext_ofs = {{(PTR_W-OFS_W){v[OFS_W-1]}}, v};
	endfunction : sext_ofs

	// File registers sit at the bottom of the write address space
	function automatic logic [PTR_W-1:0] zext_faddr(
		input logic [FADDR_W-1:0] v
	);
		zext_faddr = {{(PTR_W-FADDR_W){1'h0}}, v};
	endfunction : zext_faddr

	// Both directions wrap modulo the pointer range
	function automatic logic [PTR_W-1:0] step_ptr(
		input logic [PTR_W-1:0] v,
		input logic down
	);
		if (down)
		begin
			step_ptr = v - dmis_pkg::PTR_ONE;
		end
		else
		begin
			step_ptr = v + dmis_pkg::PTR_ONE;
		end
	endfunction : step_ptr

	dmis_state_t s_q;
	dmis_state_t s_d;
	logic [PTR_W-1:0] cur;
	logic [PTR_W-1:0] up;
	logic [PTR_W-1:0] dn;
	logic [PTR_W-1:0] rel;
	logic [PTR_W-1:0] ofs_ext;
	wire logic [PTR_W-1:0] ptr_up [NPTR];
	wire logic [PTR_W-1:0] ptr_dn [NPTR];
	wire logic [PTR_W-1:0] ptr_rel [NPTR];

	assign ofs_ext = sext_ofs(instr_i.offset); // see RULE_06

	// Candidates per pointer, so the case below only selects
	for (genvar i = 0; i < NPTR; i++)
	begin : g_ptr
		assign ptr_up[i] = step_ptr(s_q.ptr[i], 1'h0); // see RULE_08
		assign ptr_dn[i] = step_ptr(s_q.ptr[i], 1'h1); // see RULE_08
		assign ptr_rel[i] = s_q.ptr[i] + ofs_ext; // see RULE_06
	end

	always_comb
	begin
		s_d = s_q;
		s_d.wr.valid = 1'h0;
		// Flags only follow the ALU; this unit never writes them
		s_d.flags = flags_i; // see RULE_09 see RULE_10
		cur = s_q.ptr[instr_i.sel]; // see RULE_04
		up = ptr_up[instr_i.sel];
		dn = ptr_dn[instr_i.sel];
		rel = ptr_rel[instr_i.sel];

		if (instr_i.valid)
		begin
			unique case (instr_i.op)
				dmis_pkg::DMIS_OP_NONE:
				begin
					// Nothing issued this cycle
					s_d.wr.valid = 1'h0;
				end
				dmis_pkg::DMIS_OP_LIT:
				begin
					s_d.acc = instr_i.literal; // see RULE_01 see RULE_10
				end
				dmis_pkg::DMIS_OP_DIR:
				begin
					s_d.wr.valid = 1'h1; // see RULE_02
					s_d.wr.indirect = 1'h0;
					s_d.wr.addr = zext_faddr(instr_i.faddr);
					s_d.wr.data = s_q.acc;
				end
				dmis_pkg::DMIS_OP_IND:
				begin
					// Window is only an address path, never storage
					s_d.wr.valid = 1'h1; // see RULE_03
					s_d.wr.indirect = 1'h1;
					s_d.wr.data = s_q.acc;
					// Pre forms write the stepped value, post forms the old one
					unique case (instr_i.mode) // see RULE_05
						dmis_pkg::DMIS_PREINC:
						begin
							s_d.ptr[instr_i.sel] = up; // see RULE_07
							s_d.wr.addr = up;
						end
						dmis_pkg::DMIS_PREDEC:
						begin
							s_d.ptr[instr_i.sel] = dn; // see RULE_07
							s_d.wr.addr = dn;
						end
						dmis_pkg::DMIS_POSTINC:
						begin
							s_d.ptr[instr_i.sel] = up; // see RULE_07
							s_d.wr.addr = cur;
						end
						dmis_pkg::DMIS_POSTDEC:
						begin
							s_d.ptr[instr_i.sel] = dn; // see RULE_07
							s_d.wr.addr = cur;
						end
					endcase
				end
				dmis_pkg::DMIS_OP_REL:
				begin
					// Pointer itself stays put in this form
					s_d.wr.valid = 1'h1; // see RULE_03
					s_d.wr.indirect = 1'h1;
					s_d.wr.data = s_q.acc;
					s_d.wr.addr = rel; // see RULE_06 see RULE_07
				end
				default:
				begin
					// Unused codes do nothing rather than guess
					s_d.wr.valid = 1'h0;
				end
			endcase
		end
	end

	// Synchronous reset, so the core clock alone times every register
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s_q.acc <= dmis_pkg::ACC_RST;
			s_q.ptr <= {NPTR{dmis_pkg::PTR_RST}};
			s_q.flags <= dmis_pkg::FLAG_RST;
			s_q.wr.valid <= 1'h0;
			s_q.wr.indirect <= 1'h0;
			s_q.wr.addr <= dmis_pkg::PTR_RST;
			s_q.wr.data <= dmis_pkg::ACC_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign acc_o = s_q.acc;
	assign ptr0_o = s_q.ptr[0];
	assign ptr1_o = s_q.ptr[1];
	assign flags_o = s_q.flags;
	assign wr_o = s_q.wr;

endmodule : dmis_core

// ===== dmis_sva.sv
// Checker for the data-move unit.
// Assumes a bind onto dmis_core.
`timescale 1ns/10ps
module dmis_sva
(
	// Inputs
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input dmis_pkg::dmis_instr_t instr_i,
	input wire logic [2:0] flags_i,
	// Outputs
	input wire logic [7:0] acc_o,
	input wire logic [15:0] ptr0_o,
	input wire logic [15:0] ptr1_o,
	input wire logic [2:0] flags_o,
	input dmis_pkg::dmis_wr_t wr_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire logic v = instr_i.valid;
	wire logic [2:0] op = instr_i.op;
	a_lit_acc: assert property (v && op == 3'h1 |=>
		acc_o == $past(instr_i.literal)) else $error("literal load");
	a_dir_write: assert property (v && op == 3'h2 |=> wr_o ==
		{2'h2, 9'h000, $past(instr_i.faddr), $past(acc_o)}) else $error("dir");
	a_dir_acc: assert property (v && op == 3'h2 |=> $stable(acc_o))
		else $error("dir acc");
	a_ind_data: assert property (v && op == 3'h3 |=> wr_o.valid &&
		wr_o.indirect && wr_o.data == $past(acc_o)) else $error("ind");
	a_ptr_step: assert property (v && op == 3'h3 && !instr_i.sel |=> ptr0_o ==
		$past(ptr0_o) + ($past(instr_i.mode[0]) ? 16'hffff : 16'h0001))
		else $error("step");
	a_mode_addr: assert property (v && op == 3'h3 && !instr_i.sel |=>
		wr_o.addr == ($past(instr_i.mode[1]) ? $past(ptr0_o) : ptr0_o)) else $error("ea");
	a_rel_addr: assert property (v && op == 3'h4 && !instr_i.sel |=>
		$stable(ptr0_o) && wr_o.addr == ptr0_o +
		{{10{$past(instr_i.offset[5])}}, $past(instr_i.offset)}) else $error("rel");
	a_ptr_select: assert property (v && op == 3'h3 && instr_i.sel |=>
		$stable(ptr0_o) && ptr1_o != $past(ptr1_o)) else $error("sel");
	a_flags_kept: assert property (1 |=> flags_o == $past(flags_i))
		else $error("flags");
	a_write_cause: assert property (wr_o.valid |-> $past(v) &&
		$past(op) inside {3'h2, 3'h3, 3'h4}) else $error("write");
	c_rel: cover property (v && op == 3'h4);
	c_wrap: cover property (ptr1_o == 16'h0000 && $past(ptr1_o) == 16'hffff);
	c_lit: cover property (v && op == 3'h1);
endmodule : dmis_sva
bind dmis_core dmis_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.instr_i(instr_i), .flags_i(flags_i), .acc_o(acc_o), .ptr0_o(ptr0_o),
	.ptr1_o(ptr1_o), .flags_o(flags_o), .wr_o(wr_o));

// ===== tb.sv
// Self-checking bench for the data-move unit.
// Assumes dmis_core and its checker are compiled first.
`timescale 1ns/10ps
module tb;
	logic ref_clk_i = 0;
	logic rst_i = 1;
	dmis_pkg::dmis_instr_t instr_i = '0;
	logic [2:0] flags_i = '0;
	logic [7:0] acc_o, acc;
	logic [15:0] ptr0_o, ptr1_o, a;
	logic [15:0] p [2];
	logic [2:0] flags_o;
	dmis_pkg::dmis_wr_t wr_o, w;
	int num_errors = 0, num_checks = 0, cyc = 0;
	dmis_core uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
		.flags_i(flags_i), .acc_o(acc_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
		.flags_o(flags_o), .wr_o(wr_o));
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	task check(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value t=%0t got %h exp %h", $time, s, e);
		end
	endtask : check
	function automatic logic [15:0] stepped(input logic [15:0] v,
		input logic dn);
		return v + (dn ? 16'hffff : 16'h0001);
	endfunction : stepped
	task step(input logic [27:0] x);
		@(negedge ref_clk_i);
		instr_i = x;
		flags_i = 3'($urandom);
		w = '0;
		a = stepped(p[x[8]], x[6]);
		if (x[27] && x[26:24] == 3'h1)
			acc = x[23:16];
		else if (x[27] && x[26:24] == 3'h2)
			w = {2'h2, 9'h000, x[15:9], acc};
		else if (x[27] && x[26:24] == 3'h3)
		begin
			w = {2'h3, x[7] ? p[x[8]] : a, acc};
			p[x[8]] = a;
		end
		else if (x[27] && x[26:24] == 3'h4)
			w = {2'h3, p[x[8]] + {{10{x[5]}}, x[5:0]}, acc};
		@(posedge ref_clk_i);
		#1;
		check(acc_o, acc);
		check({ptr1_o, ptr0_o}, {p[1], p[0]});
		check(flags_o, flags_i);
		check(wr_o.valid, w.valid);
		if (w.valid)
			check(wr_o, w);
	endtask : step
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		void'($urandom(32'h587e));
		acc = '0;
		p = '{default: '0};
		repeat (5) @(negedge ref_clk_i);
		rst_i = 0;
		// Every mode on both pointers, wrapping both ways
		for (int k = 0; k < 8; k++)
			step({4'hb, 15'($urandom), k[2], k[1:0] ^ 2'h1, 6'h00});
		step({4'hc, 15'($urandom), 3'h0, 6'h20});
		step({4'hd, 15'h7fff, 3'h4, 6'h1f});
		step({4'hc, 15'h7fff, 3'h4, 6'h1f});
		step({4'h9, 8'h5a, 7'h00, 9'h000});
		step({4'ha, 8'h00, 7'h7f, 9'h000});
		$display("corner test done");
		for (int k = 0; k < 300; k++)
			step(28'($urandom));
		$display("random test done");
		end_of_test();
	end
endmodule : tb
